// [rtl/ocu_pkg.sv]
package ocu_pkg;
	// Division factor field: output = 48 MHz / (factor + 1)
	localparam int DIV_W = 4;
	localparam logic [DIV_W-1:0] FAST_DIV_RESET = 4'hB; // 48/12 = 4 MHz
	localparam int PRESC_W = 3;
	localparam logic [PRESC_W-1:0] PRESC_RESET = 3'h0;
	localparam int TRIM_W = 5;
	localparam int STARTUP_W = 3;
	localparam logic [STARTUP_W-1:0] STARTUP_RESET = 3'h0;
	// Slow start-up interval in clk cycles = STARTUP_BASE << startup field
	localparam int STARTUP_BASE = 4;
	// ULP 32k to 1.024k divide: 32768/1024 = 32, toggle every 16 inputs
	localparam int ULP_1K_HALF = 16;
	localparam int CNT_W = 16;
	typedef enum logic [1:0] {
		OCU_OFF = 2'b00,
		OCU_WAIT = 2'b01,
		OCU_RUN = 2'b11,
		OCU_STOP = 2'b10
	} ocu_fast_t;
	typedef enum logic [1:0] {
		OCU_ACTIVE = 2'b00,
		OCU_IDLE = 2'b01,
		OCU_STANDBY = 2'b11
	} ocu_cpu_mode_t;
endpackage

// [rtl/ocu_top.sv]
`timescale 1ns/1ps
`default_nettype none
// How it works
// [R1] Crystal failure drives event output when event output enable is set.
// [R2] Event output suppressed once detector has switched onto the safe clock.
// [R3] Failure interrupt, when enabled, raises a wake request in sleep.
// [R4] Fast enable one starts fast oscillator, zero stops it.
// [R5] Fast clock divided from 48 MHz by the division factor field plus one.
// [R6] Fast clock gated off consumers until fast ready reads one.
// [R7] Software re-enables fast oscillator only after ready reads zero.
// [R8] Reset leaves fast oscillator enabled, system source, at 4 MHz.
// [R9] Fast enable zero stops oscillator in every CPU mode.
// [R10] Run-in-standby and request-gated run select when fast oscillator runs.
// [R11] Slow oscillator output masked during configurable start-up interval.
// [R12] Slow ready set when stable; rising edge raises interrupt if enabled.
// [R13] Software enables 32k/1k output before clock consumers use it.
// [R14] Software disables consumer before changing its 32k source.
// [R15] ULP oscillator runs always except while power-on reset is held.
// [R16] ULP trim loaded from factory data; software write overrides it.
// [R17] Config lock blocks ULP changes until next power-on reset.
// [R18] Watchdog gets 1.024 kHz ULP output whenever it requests it.
// [R19] Safe clock is fast clock divided by two to the prescale value.
// [R20] Hardware clears switch-back once crystal clock is back in use.
// [R21] Oscillator ready flags synchronised before status or interrupt use.
module ocu_top import ocu_pkg::*; #(
	parameter int DIV_WIDTH = DIV_W
) (
	// Clock and resets
	input wire logic clk,
	input wire logic reset,
	input wire logic por_reset,
	// CPU state and requests
	input wire logic [1:0] cpu_mode,
	input wire logic periph_clk_req,
	input wire logic watchdog_clk_req,
	// Fast oscillator control and analog status
	input wire logic fast_osc_en,
	input wire logic run_in_standby,
	input wire logic request_gated_run,
	input wire logic [DIV_WIDTH-1:0] fast_osc_division_factor,
	input wire logic fast_osc_ana_ready,
	output logic fast_osc_run,
	output logic fast_osc_ready,
	output logic fast_clk_en,
	output logic fast_clk_div_pulse,
	// Slow oscillator
	input wire logic slow_osc_en,
	input wire logic [STARTUP_W-1:0] slow_startup,
	input wire logic slow_osc_ana_ready,
	input wire logic out_32k_en,
	input wire logic out_1k_en,
	input wire logic slow_irq_en,
	input wire logic slow_irq_clr,
	output logic slow_osc_ready,
	output logic slow_clk_32k_en,
	output logic slow_clk_1k_en,
	output logic slow_irq,
	// ULP oscillator
	input wire logic ulp_tick_32k,
	input wire logic [TRIM_W-1:0] factory_trim,
	input wire logic factory_trim_valid,
	input wire logic ulp_trim_we,
	input wire logic [TRIM_W-1:0] ulp_trim_wdata,
	input wire logic config_lock_set,
	output logic ulp_run,
	output logic [TRIM_W-1:0] ulp_trim,
	output logic config_lock,
	output logic watchdog_clk_1k,
	// Clock failure detector
	input wire logic crystal_fail,
	input wire logic fail_event_out_en,
	input wire logic fail_irq_en,
	input wire logic switch_back_set,
	input wire logic crystal_recovered,
	input wire logic [PRESC_W-1:0] safe_clk_prescale,
	output logic on_safe_clk,
	output logic switch_back_en,
	output logic fail_event,
	output logic wake_req,
	output logic safe_clk_pulse
);
	// Synchronisers for pin-side levels: fast ready, slow ready, fail, recovered, ulp tick
	localparam int NS = 5;
	logic [NS-1:0] s1_q, s2_q, s1_d, s2_d, s_in;
	assign s_in = {ulp_tick_32k, crystal_recovered, crystal_fail, slow_osc_ana_ready, fast_osc_ana_ready};
	always_comb begin
		s1_d = s_in;
		s2_d = s1_q;
		if (reset) begin
			s1_d = '0;
			s2_d = '0;
		end
	end
	always_ff @(posedge clk) begin
		s1_q <= s1_d;
		s2_q <= s2_d;
	end
	logic fast_rdy_s, slow_rdy_s, fail_s, recov_s, tick_s;
	// [R21] synchronised ready flags
	assign fast_rdy_s = s2_q[0];
	assign slow_rdy_s = s2_q[1];
	assign fail_s = s2_q[2];
	assign recov_s = s2_q[3];
	assign tick_s = s2_q[4];
	// Fast oscillator run request
	logic run_req;
	always_comb begin
		run_req = 1'b0;
		// [R9] [R10] mode table
		if (fast_osc_en) begin
			case (cpu_mode)
				OCU_ACTIVE, OCU_IDLE: run_req = request_gated_run ? periph_clk_req : 1'b1;
				OCU_STANDBY: run_req = run_in_standby && (!request_gated_run || periph_clk_req);
				default: run_req = 1'b0;
			endcase
		end
	end
	// Fast oscillator sequencing
	ocu_fast_t fst_q, fst_d;
	always_comb begin
		fst_d = fst_q;
		case (fst_q)
			// [R4] start on enable
			OCU_OFF: if (run_req) fst_d = OCU_WAIT;
			OCU_WAIT: begin
				if (!run_req) fst_d = OCU_STOP;
				else if (fast_rdy_s) fst_d = OCU_RUN;
			end
			OCU_RUN: if (!run_req) fst_d = OCU_STOP;
			// Stays until analog ready drops, so a quick re-enable cannot glitch
			OCU_STOP: if (!fast_rdy_s) fst_d = OCU_OFF;
			default: fst_d = OCU_OFF;
		endcase
		// [R8] enabled and running after reset
		if (reset) fst_d = OCU_WAIT;
	end
	always_ff @(posedge clk) fst_q <= fst_d;
	assign fast_osc_run = (fst_q == OCU_WAIT) || (fst_q == OCU_RUN);
	assign fast_osc_ready = fast_rdy_s;
	// [R6] consumers see clock only when ready
	assign fast_clk_en = (fst_q == OCU_RUN) && fast_rdy_s;
	// Divider and safe prescaler from the 48 MHz reference (clk stands in for it)
	logic [DIV_WIDTH-1:0] div_q, div_d;
	logic div_p_q, div_p_d;
	logic [7:0] pre_q, pre_d;
	logic safe_q, safe_d;
	always_comb begin
		div_d = div_q;
		div_p_d = 1'b0;
		pre_d = pre_q;
		safe_d = 1'b0;
		if (fast_clk_en) begin
			// [R5] divide by factor plus one
			if (div_q >= fast_osc_division_factor) begin
				div_d = '0;
				div_p_d = 1'b1;
			end else begin
				div_d = div_q + 1'b1;
			end
			// [R19] divide by 2^P
			pre_d = pre_q + 8'h01;
			safe_d = ((pre_q & ((8'h01 << safe_clk_prescale) - 8'h01)) == 8'h00);
		end
		if (reset) begin
			div_d = '0;
			div_p_d = 1'b0;
			pre_d = 8'h00;
			safe_d = 1'b0;
		end
	end
	always_ff @(posedge clk) begin
		div_q <= div_d;
		div_p_q <= div_p_d;
		pre_q <= pre_d;
		safe_q <= safe_d;
	end
	assign fast_clk_div_pulse = div_p_q;
	assign safe_clk_pulse = safe_q;
	// Slow oscillator start-up mask and ready interrupt
	logic [CNT_W-1:0] su_q, su_d;
	logic srdy_q, srdy_d, sirq_q, sirq_d;
	always_comb begin
		su_d = su_q;
		srdy_d = srdy_q;
		sirq_d = sirq_q;
		if (!slow_osc_en) begin
			su_d = '0;
			srdy_d = 1'b0;
		// [R11] count start-up interval
		end else if (!srdy_q) begin
			if (su_q >= CNT_W'(STARTUP_BASE << slow_startup) && slow_rdy_s) srdy_d = 1'b1;
			else su_d = su_q + 1'b1;
		end
		// [R12] set wins over clear
		if (slow_irq_clr) sirq_d = 1'b0;
		if (srdy_d && !srdy_q && slow_irq_en) sirq_d = 1'b1;
		if (reset) begin
			su_d = '0;
			srdy_d = 1'b0;
			sirq_d = 1'b0;
		end
	end
	always_ff @(posedge clk) begin
		su_q <= su_d;
		srdy_q <= srdy_d;
		sirq_q <= sirq_d;
	end
	assign slow_osc_ready = srdy_q;
	assign slow_irq = sirq_q;
	// [R11] masked output enables
	assign slow_clk_32k_en = srdy_q && out_32k_en;
	assign slow_clk_1k_en = srdy_q && out_1k_en;
	// ULP oscillator: state held on power-on reset only
	logic [TRIM_W-1:0] trim_q, trim_d;
	logic lock_q, lock_d, loaded_q, loaded_d, tick_q, tick_d, w1k_q, w1k_d;
	logic [4:0] k_q, k_d;
	always_comb begin
		trim_d = trim_q;
		lock_d = lock_q;
		loaded_d = loaded_q;
		tick_d = tick_s;
		w1k_d = w1k_q;
		k_d = k_q;
		// [R16] factory load once at start-up
		if (!loaded_q && factory_trim_valid) begin
			trim_d = factory_trim;
			loaded_d = 1'b1;
		end
		// [R17] [R16] override unless locked
		if (!lock_q && ulp_trim_we) trim_d = ulp_trim_wdata;
		if (config_lock_set) lock_d = 1'b1;
		// [R18] 1.024 kHz from 32 kHz ticks while requested
		if (tick_s && !tick_q && watchdog_clk_req) begin
			if (k_q == 5'(ULP_1K_HALF - 1)) begin
				k_d = '0;
				w1k_d = !w1k_q;
			end else begin
				k_d = k_q + 5'h01;
			end
		end
		if (!watchdog_clk_req) begin
			k_d = '0;
			w1k_d = 1'b0;
		end
		// [R15] only power-on reset stops or clears it
		if (por_reset) begin
			trim_d = '0;
			lock_d = 1'b0;
			loaded_d = 1'b0;
			tick_d = 1'b0;
			w1k_d = 1'b0;
			k_d = '0;
		end
	end
	always_ff @(posedge clk) begin
		trim_q <= trim_d;
		lock_q <= lock_d;
		loaded_q <= loaded_d;
		tick_q <= tick_d;
		w1k_q <= w1k_d;
		k_q <= k_d;
	end
	assign ulp_run = !por_reset;
	assign ulp_trim = trim_q;
	assign config_lock = lock_q;
	assign watchdog_clk_1k = w1k_q;
	// Clock failure detector
	logic safe_sel_q, safe_sel_d, swb_q, swb_d, ev_q, ev_d, wk_q, wk_d;
	always_comb begin
		safe_sel_d = safe_sel_q;
		swb_d = swb_q;
		if (fail_s && !swb_q) safe_sel_d = 1'b1;
		if (switch_back_set && safe_sel_q) swb_d = 1'b1;
		// [R20] self-clear after return to crystal
		if (swb_q && recov_s) begin
			safe_sel_d = 1'b0;
			swb_d = 1'b0;
		end
		// [R1] [R2] event only before safe switch
		ev_d = fail_s && fail_event_out_en && !safe_sel_q;
		// [R3] wake request
		wk_d = fail_s && fail_irq_en;
		if (reset) begin
			safe_sel_d = 1'b0;
			swb_d = 1'b0;
			ev_d = 1'b0;
			wk_d = 1'b0;
		end
	end
	always_ff @(posedge clk) begin
		safe_sel_q <= safe_sel_d;
		swb_q <= swb_d;
		ev_q <= ev_d;
		wk_q <= wk_d;
	end
	assign on_safe_clk = safe_sel_q;
	assign switch_back_en = swb_q;
	assign fail_event = ev_q;
	assign wake_req = wk_q;
	// Checks
	property p_event_gate;
		@(posedge clk) disable iff (reset) fail_event |-> $past(fail_event_out_en) && !$past(safe_sel_q);
	endproperty
	a_event_gate: assert property (p_event_gate) else $error("event while disabled or on safe clock"); // [R1]
	property p_no_event_safe;
		@(posedge clk) disable iff (reset) safe_sel_q ##1 safe_sel_q |-> !fail_event;
	endproperty
	a_no_event_safe: assert property (p_no_event_safe) else $error("event on safe clock"); // [R2]
	property p_wake;
		@(posedge clk) disable iff (reset) (fail_s && fail_irq_en) |=> wake_req;
	endproperty
	a_wake: assert property (p_wake) else $error("no wake request"); // [R3]
	property p_gate;
		@(posedge clk) disable iff (reset) fast_clk_en |-> fast_rdy_s && fast_osc_run;
	endproperty
	a_gate: assert property (p_gate) else $error("fast clock ungated before ready"); // [R6]
	property p_disable;
		@(posedge clk) disable iff (reset) !fast_osc_en [*2] |-> fst_q != OCU_RUN;
	endproperty
	a_disable: assert property (p_disable) else $error("fast runs while disabled"); // [R9]
	property p_mask;
		@(posedge clk) disable iff (reset) slow_clk_32k_en |-> slow_osc_ready;
	endproperty
	a_mask: assert property (p_mask) else $error("slow clock unmasked early"); // [R11]
	property p_sirq;
		@(posedge clk) disable iff (reset) ($rose(srdy_q) && $past(slow_irq_en)) |-> slow_irq;
	endproperty
	a_sirq: assert property (p_sirq) else $error("slow ready interrupt lost"); // [R12]
	property p_lock;
		@(posedge clk) disable iff (por_reset) (lock_q && !$past(por_reset)) |=> $stable(trim_q) || !$past(loaded_q);
	endproperty
	a_lock: assert property (p_lock) else $error("trim changed while locked"); // [R17]
	property p_swb;
		@(posedge clk) disable iff (reset) (swb_q && recov_s) |=> !switch_back_en && !on_safe_clk;
	endproperty
	a_swb: assert property (p_swb) else $error("switch back not cleared"); // [R20]
endmodule
`default_nettype wire

// [tb/ocu_osc_model.sv]
`timescale 1ns/1ps
`default_nettype none
module ocu_osc_model #(
	parameter int FAST_DLY = 4,
	parameter int SLOW_DLY = 4,
	parameter int TICK_HALF = 4
) (
	// Clock
	input wire logic clk,
	// Oscillator enables
	input wire logic fast_osc_run,
	input wire logic slow_osc_en,
	// Analog ready flags and ULP clock
	output logic fast_osc_ana_ready,
	output logic slow_osc_ana_ready,
	output logic ulp_tick_32k
);
	// Ready drops at once when disabled, no grace period
	int fc = 0;
	int sc = 0;
	int tc = 0;
	always @(posedge clk) begin
		fc <= fast_osc_run ? (fc < FAST_DLY ? fc + 1 : fc) : 0;
		sc <= slow_osc_en ? (sc < SLOW_DLY ? sc + 1 : sc) : 0;
		tc <= tc == 2 * TICK_HALF - 1 ? 0 : tc + 1;
	end
	assign fast_osc_ana_ready = fc == FAST_DLY;
	assign slow_osc_ana_ready = sc == SLOW_DLY;
	// Free running, even through resets
	assign ulp_tick_32k = tc >= TICK_HALF;
endmodule
`default_nettype wire

// [tb/oscillator_control_unit_tb.sv]
`timescale 1ns/1ps
`default_nettype none
module oscillator_control_unit_tb import ocu_pkg::*;;
	logic clk, reset, por_reset, periph_clk_req, watchdog_clk_req, fast_osc_en, run_in_standby, request_gated_run;
	logic [1:0] cpu_mode;
	logic [DIV_W-1:0] fast_osc_division_factor;
	logic fast_osc_ana_ready, fast_osc_run, fast_osc_ready, fast_clk_en, fast_clk_div_pulse;
	logic slow_osc_en, slow_osc_ana_ready, out_32k_en, out_1k_en, slow_irq_en, slow_irq_clr;
	logic [STARTUP_W-1:0] slow_startup;
	logic slow_osc_ready, slow_clk_32k_en, slow_clk_1k_en, slow_irq;
	logic ulp_tick_32k, factory_trim_valid, ulp_trim_we, config_lock_set, ulp_run, config_lock, watchdog_clk_1k;
	logic [TRIM_W-1:0] factory_trim, ulp_trim_wdata, ulp_trim;
	logic crystal_fail, fail_event_out_en, fail_irq_en, switch_back_set, crystal_recovered;
	logic [PRESC_W-1:0] safe_clk_prescale;
	logic on_safe_clk, switch_back_en, fail_event, wake_req, safe_clk_pulse;
	logic [1:0] sel;
	logic pm;
	logic [15:0] cnt;
	int mismatches = 0;
	int n_checks = 0;
	int cycles = 0;
	// Rows: enable, standby run, gated, mode, request, expected run
	localparam logic [6:0] ROWS [0:7] = '{7'h41, 7'h50, 7'h53, 7'h57, 7'h45, 7'h6D, 7'h2C, 7'h00};
	localparam logic [DIV_W-1:0] FACS [0:2] = '{FAST_DIV_RESET, 4'h1, 4'hF};

	ocu_top i_ocu_top (.clk, .reset, .por_reset, .cpu_mode, .periph_clk_req, .watchdog_clk_req, .fast_osc_en,
		.run_in_standby, .request_gated_run, .fast_osc_division_factor, .fast_osc_ana_ready, .fast_osc_run,
		.fast_osc_ready, .fast_clk_en, .fast_clk_div_pulse, .slow_osc_en, .slow_startup, .slow_osc_ana_ready,
		.out_32k_en, .out_1k_en, .slow_irq_en, .slow_irq_clr, .slow_osc_ready, .slow_clk_32k_en,
		.slow_clk_1k_en, .slow_irq, .ulp_tick_32k, .factory_trim, .factory_trim_valid, .ulp_trim_we,
		.ulp_trim_wdata, .config_lock_set, .ulp_run, .ulp_trim, .config_lock, .watchdog_clk_1k, .crystal_fail,
		.fail_event_out_en, .fail_irq_en, .switch_back_set, .crystal_recovered, .safe_clk_prescale,
		.on_safe_clk, .switch_back_en, .fail_event, .wake_req, .safe_clk_pulse);
	ocu_osc_model i_ocu_osc_model (.clk, .fast_osc_run, .slow_osc_en, .fast_osc_ana_ready,
		.slow_osc_ana_ready, .ulp_tick_32k);

	assign pm = sel == 2'h0 ? fast_clk_div_pulse : sel == 2'h1 ? safe_clk_pulse : watchdog_clk_1k;

	initial begin
		clk = 0;
		forever #4 clk = ~clk;
	end

	task chk(input logic [15:0] got, input logic [15:0] exp);
		n_checks++;
		if (got !== exp) begin
			mismatches++;
			$display("[ERR] %0t got %h exp %h", $time, got, exp);
		end
	endtask

	task final_report;
		$display("checks %0d mismatches %0d", n_checks, mismatches);
		if (mismatches == 0 && n_checks > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask

	task cyc(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask

	// Rising edge to rising edge of the selected clock output
	task per(input logic [1:0] s, input logic [15:0] e);
		logic [15:0] n;
		logic pv;
		logic r;
		sel = s;
		// Let the selector settle so switching it cannot fake a start edge
		cyc(1);
		@(posedge pm);
		n = 0;
		pv = 1;
		do begin
			cyc(1);
			n++;
			r = pm && !pv;
			pv = pm;
		end while (!r);
		chk(n, e);
	endtask

	// Generous ceiling, the full run needs about 900 cycles
	always @(posedge clk) begin
		cycles++;
		if (cycles == 20000) begin
			mismatches++;
			final_report;
		end
	end

	initial begin
		{periph_clk_req, watchdog_clk_req, run_in_standby, request_gated_run, slow_osc_en, out_32k_en} = '0;
		{out_1k_en, slow_irq_en, slow_irq_clr, ulp_trim_we, ulp_trim_wdata, config_lock_set} = '0;
		{crystal_fail, fail_event_out_en, fail_irq_en, switch_back_set, crystal_recovered} = '0;
		{reset, por_reset, fast_osc_en, factory_trim_valid} = 4'hF;
		cpu_mode = OCU_ACTIVE;
		fast_osc_division_factor = FAST_DIV_RESET;
		factory_trim = 5'h15;
		slow_startup = 3'h2;
		safe_clk_prescale = 3'h3;
		sel = 2'h0;
		cnt = 16'h0000;
		cyc(9);
		chk(16'({fast_osc_run, fast_clk_en, ulp_run}), 16'h0004);
		@(posedge clk);
		reset <= 0;
		por_reset <= 0;
		cyc(30);
		chk(16'({fast_clk_en, ulp_run, ulp_trim}), 16'h0075);
		$display("test reset done");
		foreach (FACS[i]) begin
			@(posedge clk);
			fast_osc_division_factor <= FACS[i];
			cyc(20);
			per(2'h0, 16'(FACS[i]) + 16'h0001);
		end
		$display("test divider done");
		foreach (ROWS[i]) begin
			@(posedge clk);
			{fast_osc_en, run_in_standby, request_gated_run, cpu_mode, periph_clk_req} <= ROWS[i][6:1];
			cyc(24);
			chk(16'({fast_osc_run, fast_clk_en}), 16'({2{ROWS[i][0]}}));
		end
		$display("test modes done");
		for (int i = 0; i < 50 && fast_osc_ready !== 1'h0; i++) cyc(1);
		@(posedge clk);
		{fast_osc_en, run_in_standby, request_gated_run, cpu_mode, periph_clk_req} <= 6'h20;
		cyc(2);
		chk(16'({fast_osc_ready, fast_clk_en}), 16'h0000);
		cyc(20);
		chk(16'({fast_osc_ready, fast_clk_en}), 16'h0003);
		$display("test restart done");
		// outputs enabled along with the oscillator
		@(posedge clk);
		{slow_osc_en, out_32k_en, out_1k_en, slow_irq_en} <= 4'hF;
		cyc(10);
		chk(16'({slow_osc_ready, slow_clk_32k_en, slow_irq}), 16'h0000);
		cyc(30);
		chk(16'({slow_osc_ready, slow_clk_32k_en, slow_clk_1k_en, slow_irq}), 16'h000F);
		@(posedge clk);
		slow_irq_clr <= 1;
		@(posedge clk);
		slow_irq_clr <= 0;
		cyc(2);
		chk(16'(slow_irq), 16'h0000);
		// consumers let go of the outputs before any source change
		@(posedge clk);
		{out_32k_en, out_1k_en} <= 2'h0;
		cyc(2);
		chk(16'({slow_osc_ready, slow_clk_32k_en, slow_clk_1k_en}), 16'h0004);
		$display("test slow done");
		@(posedge clk);
		watchdog_clk_req <= 1;
		ulp_trim_we <= 1;
		ulp_trim_wdata <= 5'h0A;
		@(posedge clk);
		ulp_trim_we <= 0;
		config_lock_set <= 1;
		@(posedge clk);
		config_lock_set <= 0;
		ulp_trim_we <= 1;
		ulp_trim_wdata <= 5'h03;
		@(posedge clk);
		ulp_trim_we <= 0;
		reset <= 1;
		cyc(4);
		chk(16'({config_lock, ulp_trim}), 16'h002A);
		@(posedge clk);
		reset <= 0;
		per(2'h2, 16'h0100);
		@(posedge clk);
		por_reset <= 1;
		cyc(2);
		chk(16'(ulp_run), 16'h0000);
		@(posedge clk);
		por_reset <= 0;
		cyc(4);
		chk(16'({config_lock, ulp_trim}), 16'h0015);
		$display("test ulp done");
		@(posedge clk);
		{fail_event_out_en, fail_irq_en, crystal_fail} <= 3'h7;
		repeat (10) begin
			cyc(1);
			cnt = cnt + 16'(fail_event);
		end
		chk(cnt, 16'h0001);
		chk(16'({on_safe_clk, wake_req}), 16'h0003);
		per(2'h1, 16'h0008);
		@(posedge clk);
		switch_back_set <= 1;
		@(posedge clk);
		switch_back_set <= 0;
		cyc(2);
		chk(16'(switch_back_en), 16'h0001);
		@(posedge clk);
		{crystal_fail, crystal_recovered} <= 2'h1;
		cyc(6);
		chk(16'({on_safe_clk, switch_back_en}), 16'h0000);
		// Failure with event output and interrupt disabled must stay silent
		@(posedge clk);
		{fail_event_out_en, fail_irq_en, crystal_fail} <= 3'h1;
		cnt = 16'h0000;
		repeat (10) begin
			cyc(1);
			cnt = cnt + 16'(fail_event);
		end
		chk(cnt, 16'h0000);
		chk(16'({on_safe_clk, wake_req}), 16'h0002);
		$display("test fail detector done");
		final_report;
	end
endmodule
`default_nettype wire
